// >>> lpw_pkg.sv
//
// Contract
// R1: A low manual power-cut input switches the target supply off.
// R2: After a manual cut the supply stays off at least the hold time.
// R3: Hold time is 16 to 2000 ms in 8 ms steps, default 1000 ms.
// R4: Heartbeat timeout is 16 to 2000 ms in 8 ms steps, default 500 ms.
// R5: No heartbeat edge within the timeout switches the supply off.
// R6: The heartbeat timer starts counting as soon as power is applied.
// R7: Any heartbeat edge before timeout clears the timer to zero.
// R8: On timer overflow the supply goes off for at least the hold time.
// R9: Probe drives low, high, low; if heartbeat follows all, timer clears.
// R10: Watchdog is suspended only for an undriven, unpulled heartbeat input.
// R11: A driven or pulled-up heartbeat input never reads as undriven.
// R12: The processor holds each input level at least 6 ms, within timeout.
// R13: The processor should toggle heartbeat from a dedicated output pin.
// R14: At power-up, with power-cut high, wait the hold time then enable.
// R15: Probe, power-cut, edge and timer checks run once per 5.12 ms loop.
// R16: After any power cut the full power-up sequence restarts.
// R17: Both timeouts are counts of an 8 ms tick on one shared timer.
// R18: Supply stays off from reset until the power-up sequence ends.
//
package lpw_pkg;

   // ----------------------------------------------------------------
   // Timing figures.
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 200000;
   localparam int STEP_MS = 8;
   localparam int LOOP_US = 5120;
   localparam int HOLD_MS = 1000;
   localparam int WD_MS = 500;
   localparam int MIN_MS = 16;
   localparam int MAX_MS = 2000;
   localparam int STEP_CYC = STEP_MS * CLK_KHZ;
   localparam int LOOP_CYC = (LOOP_US * CLK_KHZ) / 1000;
   localparam int PROBE_SETTLE_CYC = 8;
   localparam int TMR_W = 9;

   // ----------------------------------------------------------------
   // Supervisor states.
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_RUN = 3'b010,
      ST_PROBE = 3'b100
   } lpw_state_t;

endpackage : lpw_pkg

// >>> lpw_tick_if.sv
`timescale 1ns/1ps
// Carries the 8 ms step and loop pulses from the tick generator.
interface lpw_tick_if;
   logic step_tick;
   logic loop_tick;
   logic step_restart;
   modport gen (output step_tick, output loop_tick, input step_restart);
   modport use_side (input step_tick, input loop_tick, output step_restart);
endinterface : lpw_tick_if

// >>> lpw_tick_gen.sv
`timescale 1ns/1ps
module lpw_tick_gen #(
   parameter int STEP_CYC = lpw_pkg::STEP_CYC,
   parameter int LOOP_CYC = lpw_pkg::LOOP_CYC
) (
   // Clock, reset and enable.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Tick pulses.
   lpw_tick_if.gen tk
);

   localparam int SW = $clog2(STEP_CYC + 1);
   localparam int LW = $clog2(LOOP_CYC + 1);
   localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);
   localparam logic [LW-1:0] LOOP_LAST = LW'(LOOP_CYC - 1);

   logic [SW-1:0] step_cnt_q;
   logic [LW-1:0] loop_cnt_q;

   // R17 shared 8 ms tick
   // The step divider restarts with the timer so every timer count is a whole step.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt_q <= '0;
      end else if (clk_en) begin
         if (tk.step_restart || step_cnt_q == STEP_LAST) begin
            step_cnt_q <= '0;
         end else begin
            step_cnt_q <= step_cnt_q + 1'b1;
         end
      end
   end

   // R15 loop period divider
   // The loop divider runs free and paces the periodic checks.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         loop_cnt_q <= '0;
      end else if (clk_en) begin
         if (loop_cnt_q == LOOP_LAST) begin
            loop_cnt_q <= '0;
         end else begin
            loop_cnt_q <= loop_cnt_q + 1'b1;
         end
      end
   end

   // Pulses last one enabled cycle.
   assign tk.step_tick = clk_en && !tk.step_restart && (step_cnt_q == STEP_LAST);
   assign tk.loop_tick = clk_en && (loop_cnt_q == LOOP_LAST);

endmodule : lpw_tick_gen

// >>> lpw_watchdog.sv
`timescale 1ns/1ps
module lpw_watchdog #(
   parameter int STEP_CYC = lpw_pkg::STEP_CYC,
   parameter int LOOP_CYC = lpw_pkg::LOOP_CYC,
   parameter int HOLD_MS = lpw_pkg::HOLD_MS,
   parameter int WD_MS = lpw_pkg::WD_MS
) (
   // Clock, reset and enable.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Inputs from the monitored processor.
   input wire logic manual_power_cut_n,
   input wire logic heartbeat_in,
   // Probe pin that pulls the heartbeat line through a resistor.
   output logic probe_drive_pin,
   output logic probe_drive_oe,
   // Supply switch and status.
   output logic target_supply,
   output logic watchdog_suspended
);

   // ----------------------------------------------------------------
   // Timeout counts in 8 ms steps.
   // ----------------------------------------------------------------
   localparam int TW = lpw_pkg::TMR_W;
   // R3 hold time in steps
   localparam logic [TW-1:0] HOLD_TICKS = TW'(HOLD_MS / lpw_pkg::STEP_MS);
   // R4 heartbeat timeout in steps
   localparam logic [TW-1:0] WD_TICKS = TW'(WD_MS / lpw_pkg::STEP_MS);
   localparam logic [TW-1:0] TMR_MAX = {TW{1'b1}};
   localparam logic [3:0] SETTLE_LAST = 4'(lpw_pkg::PROBE_SETTLE_CYC - 1);

   lpw_tick_if tk ();

   lpw_tick_gen #(
      .STEP_CYC(STEP_CYC),
      .LOOP_CYC(LOOP_CYC)
   ) u_tick (
      .clock(clock),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .tk(tk)
   );

   // ----------------------------------------------------------------
   // Input synchronisers.
   // ----------------------------------------------------------------
   logic mr_meta_q;
   logic mr_s_q;
   logic hb_meta_q;
   logic hb_s_q;

   // Two flops per pin before any logic looks at the level.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mr_meta_q <= 1'b1;
         mr_s_q <= 1'b1;
         hb_meta_q <= 1'b0;
         hb_s_q <= 1'b0;
      end else if (clk_en) begin
         mr_meta_q <= manual_power_cut_n;
         mr_s_q <= mr_meta_q;
         hb_meta_q <= heartbeat_in;
         hb_s_q <= hb_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer state.
   // ----------------------------------------------------------------
   lpw_pkg::lpw_state_t state_q;
   logic [1:0] step_q;
   logic [3:0] settle_q;
   logic follow_q;
   logic hb_last_q;
   logic [TW-1:0] tmr_q;
   logic settle_done;
   logic eval;
   logic hb_edge;
   logic follow_all;
   logic power_up;
   logic cut;
   logic tmr_clr;

   assign settle_done = (settle_q == SETTLE_LAST);
   assign eval = (state_q == lpw_pkg::ST_PROBE) && (step_q == 2'h3) && settle_done;
   assign hb_edge = (hb_s_q != hb_last_q);
   assign follow_all = follow_q;
   // R14 wait hold time then power up
   assign power_up = (state_q == lpw_pkg::ST_HOLD) && mr_s_q && (tmr_q >= HOLD_TICKS);
   // R1 manual cut, R5 missing edge
   assign cut = eval && (!mr_s_q || (!hb_edge && !follow_all && tmr_q >= WD_TICKS));
   // R7 edge clear, R9 undriven clear, R6 start at power-up
   assign tmr_clr = power_up || cut || (state_q == lpw_pkg::ST_HOLD && !mr_s_q) ||
                    (eval && (hb_edge || follow_all));
   assign tk.step_restart = clk_en && tmr_clr;

   // R16 restart power-up after every cut
   // Main sequencer: hold with supply off, run, probe and evaluate.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= lpw_pkg::ST_HOLD;
      end else if (clk_en) begin
         unique case (state_q)
            lpw_pkg::ST_HOLD: begin
               if (power_up) begin
                  state_q <= lpw_pkg::ST_RUN;
               end
            end
            lpw_pkg::ST_RUN: begin
               // R15 one check per loop
               if (tk.loop_tick) begin
                  state_q <= lpw_pkg::ST_PROBE;
               end
            end
            lpw_pkg::ST_PROBE: begin
               if (cut) begin
                  state_q <= lpw_pkg::ST_HOLD;
               end else if (eval) begin
                  state_q <= lpw_pkg::ST_RUN;
               end
            end
            default: begin
               state_q <= lpw_pkg::ST_HOLD;
            end
         endcase
      end
   end

   // R9 low high low probe
   // Probe steps 0..2 drive low, high, low; step 3 releases and lets the line settle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         step_q <= 2'h0;
         settle_q <= 4'h0;
         follow_q <= 1'b0;
      end else if (clk_en) begin
         if (state_q != lpw_pkg::ST_PROBE) begin
            step_q <= 2'h0;
            settle_q <= 4'h0;
            follow_q <= 1'b1;
         end else if (settle_done) begin
            settle_q <= 4'h0;
            step_q <= step_q + 2'h1;
            // R11 a driven line fails to follow
            if (step_q != 2'h3 && hb_s_q != (step_q == 2'h1)) begin
               follow_q <= 1'b0;
            end
         end else begin
            settle_q <= settle_q + 4'h1;
         end
      end
   end

   // Probe pin drive, enabled only during the three driven steps.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         probe_drive_pin <= 1'b0;
         probe_drive_oe <= 1'b0;
      end else if (clk_en) begin
         if (state_q == lpw_pkg::ST_PROBE && !(step_q == 2'h3 || (step_q == 2'h2 && settle_done))) begin
            probe_drive_oe <= 1'b1;
            probe_drive_pin <= (step_q == 2'h1) && !settle_done || (step_q == 2'h0 && settle_done);
         end else begin
            probe_drive_oe <= 1'b0;
            probe_drive_pin <= 1'b0;
         end
      end
   end

   // R17 shared step timer
   // One saturating timer counts steps for both the hold and the heartbeat timeout.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= '0;
      end else if (clk_en) begin
         if (tmr_clr) begin
            tmr_q <= '0;
         end else if (tk.step_tick && tmr_q != TMR_MAX) begin
            tmr_q <= tmr_q + 1'b1;
         end
      end
   end

   // Last heartbeat level seen at power-up or at an evaluation point.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hb_last_q <= 1'b0;
      end else if (clk_en) begin
         if (power_up) begin
            hb_last_q <= hb_s_q;
         end else if (eval) begin
            hb_last_q <= hb_s_q;
         end
      end
   end

   // R18 supply off from reset
   // Supply switch and the suspension flag.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         target_supply <= 1'b0;
         watchdog_suspended <= 1'b0;
      end else if (clk_en) begin
         if (power_up) begin
            target_supply <= 1'b1;
         end else if (cut) begin
            // R8 overflow cuts the supply
            target_supply <= 1'b0;
         end
         // R10 suspended only when line follows the probe
         if (eval) begin
            watchdog_suspended <= follow_all;
         end else if (state_q == lpw_pkg::ST_HOLD) begin
            watchdog_suspended <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Check helpers.
   // ----------------------------------------------------------------
   logic [31:0] off_cyc_q;

   // Enabled cycles spent with the supply off, so the hold is checked in cycles, not steps.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         off_cyc_q <= '0;
      end else if (clk_en) begin
         if (target_supply) begin
            off_cyc_q <= '0;
         end else if (off_cyc_q != 32'hFFFFFFFF) begin
            off_cyc_q <= off_cyc_q + 32'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_hold_cycles: assert property ($rose(target_supply) |->
      off_cyc_q >= 32'(HOLD_TICKS) * 32'(STEP_CYC)) // R8
      else $error("Supply off for fewer cycles than the hold time.");
   chk_mr_hold_clears: assert property (state_q == lpw_pkg::ST_HOLD && clk_en && !mr_s_q |=>
      tmr_q == '0 && !target_supply) // R2
      else $error("Held power-cut did not keep the hold timer cleared.");
   chk_probe_oe_only: assert property (probe_drive_oe |-> state_q == lpw_pkg::ST_PROBE) // R9
      else $error("Probe pin driven outside the probe sequence.");
   chk_probe_low_step: assert property (state_q == lpw_pkg::ST_PROBE && step_q == 2'h0 &&
      settle_q == 4'h2 |-> probe_drive_oe && !probe_drive_pin) // R9
      else $error("Probe not driving low in its first step.");
   chk_probe_released: assert property (state_q == lpw_pkg::ST_PROBE && step_q == 2'h3 &&
      settle_q == 4'h2 |-> !probe_drive_oe) // R9
      else $error("Probe pin still driven in the release step.");
   chk_hold_unsuspends: assert property (state_q == lpw_pkg::ST_HOLD && clk_en |=>
      !watchdog_suspended) // R10
      else $error("Suspension flag kept while holding.");
   chk_eval_returns: assert property (eval && clk_en && !cut |=>
      state_q == lpw_pkg::ST_RUN) // R15
      else $error("Check without a cut did not return to run.");
   chk_run_supply_on: assert property (state_q == lpw_pkg::ST_RUN |-> target_supply) // R14
      else $error("Supply off while running.");

   chk_mr_cut_off: assert property (eval && clk_en && !mr_s_q |=> !target_supply) // R1
      else $error("Manual cut did not remove the supply.");
   chk_hold_min_time: assert property ($rose(target_supply) |-> $past(tmr_q) >= HOLD_TICKS) // R2
      else $error("Supply came back before the hold time.");
   chk_hold_supply_off: assert property (state_q == lpw_pkg::ST_HOLD |-> !target_supply) // R18
      else $error("Supply on while holding.");
   chk_wd_timeout_cut: assert property (eval && clk_en && mr_s_q && !hb_edge && !follow_all &&
      tmr_q >= WD_TICKS |=> !target_supply && state_q == lpw_pkg::ST_HOLD) // R5
      else $error("Heartbeat timeout did not cut the supply.");
   chk_edge_clears: assert property (eval && clk_en && mr_s_q && hb_edge |=> tmr_q == '0) // R7
      else $error("Heartbeat edge did not clear the timer.");
   chk_run_starts_zero: assert property ($rose(target_supply) |-> tmr_q == '0) // R6
      else $error("Timer not cleared at power-up.");
   chk_probe_high_step: assert property (state_q == lpw_pkg::ST_PROBE && step_q == 2'h1 &&
      settle_q == 4'h2 |-> probe_drive_oe && probe_drive_pin) // R9
      else $error("Probe not driving high in its second step.");
   chk_suspend_clears: assert property (eval && clk_en && mr_s_q && follow_all |=>
      tmr_q == '0 && watchdog_suspended) // R10
      else $error("Undriven line did not suspend the timer.");
   chk_loop_starts: assert property (state_q == lpw_pkg::ST_RUN && tk.loop_tick |=>
      state_q == lpw_pkg::ST_PROBE) // R15
      else $error("Loop tick did not start a check.");
   chk_cut_restarts: assert property ($fell(target_supply) |-> state_q == lpw_pkg::ST_HOLD) // R16
      else $error("Cut did not restart the power-up sequence.");

endmodule : lpw_watchdog

// >>> lpw_proc_model.sv
`timescale 1ns/1ps
// Monitored processor: drives or releases the heartbeat line beside the probe pin.
module lpw_proc_model (
   // Clock and bench control.
   input wire logic clock,
   input wire logic [1:0] mode,
   input wire logic [7:0] hold_cyc,
   // Probe pin of the supervisor.
   input wire logic probe_drive_pin,
   input wire logic probe_drive_oe,
   // Resolved heartbeat line.
   output logic heartbeat_in
);
   logic drv_q = 1'b0;
   logic junk_q = 1'b0;
   int cnt = 0;

   // level hold time
   // Toggles a dedicated output, holding each level for hold_cyc + 1 cycles.
   always @(negedge clock) begin
      junk_q <= ~junk_q;
      if (mode == 2'h0) begin
         if (cnt >= int'(hold_cyc)) begin
            cnt <= 0;
            drv_q <= ~drv_q;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end

   // Mode 1 holds the level, 2 floats without pull-up, 3 floats pulled high.
   always_comb begin
      if (mode[1] == 1'b0) begin
         heartbeat_in = drv_q;
      end else if (mode[0]) begin
         heartbeat_in = 1'b1;
      end else if (probe_drive_oe) begin
         heartbeat_in = probe_drive_pin;
      end else begin
         heartbeat_in = junk_q; // A floating line holds no stable level.
      end
   end
endmodule : lpw_proc_model

// >>> tb_latchup_power_cycle_watchdog.sv
`timescale 1ns/1ps
module tb_latchup_power_cycle_watchdog;
   // ----------------------------------------------------------------
   // Shortened timing and bench state.
   // ----------------------------------------------------------------
   localparam int STEP = 40;
   localparam int LOOP = 50;
   localparam int HOLD = (32 / lpw_pkg::STEP_MS) * STEP;
   localparam int WD = (48 / lpw_pkg::STEP_MS) * STEP;
   localparam int SLACK = LOOP + STEP + 40;
   // Watchdog span: just under twice the most cycles that all scenarios can need together.
   localparam int LIMIT = 60 * WD;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic manual_power_cut_n = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [7:0] hold_cyc = 8'h3C;
   logic [7:0] lfsr = 8'h54;
   logic heartbeat_in;
   logic probe_drive_pin;
   logic probe_drive_oe;
   logic target_supply;
   logic watchdog_suspended;
   logic [1:0] fault [2] = '{2'h1, 2'h3};
   int errors = 0;
   int comparisons = 0;
   int n;

   lpw_watchdog #(.STEP_CYC(STEP), .LOOP_CYC(LOOP), .HOLD_MS(32), .WD_MS(48)) dut (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .manual_power_cut_n(manual_power_cut_n), .heartbeat_in(heartbeat_in),
      .probe_drive_pin(probe_drive_pin), .probe_drive_oe(probe_drive_oe),
      .target_supply(target_supply), .watchdog_suspended(watchdog_suspended)
   );

   lpw_proc_model proc (
      .clock(clock), .mode(mode), .hold_cyc(hold_cyc), .probe_drive_pin(probe_drive_pin),
      .probe_drive_oe(probe_drive_oe), .heartbeat_in(heartbeat_in)
   );

   // Free-running clock.
   initial begin
      forever #2.5 clock = ~clock;
   end

   // Next value of the stimulus shift register.
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   // Random level hold between one loop and well under the timeout.
   always @(negedge clock) begin
      lfsr <= lfsr_next(lfsr);
      hold_cyc <= 8'(LOOP + 10) + {2'h0, lfsr[5:0]};
   end

   // Compares a count with its allowed window.
   task automatic check(input string what, input int lo, input int hi, input int seen);
      comparisons++;
      if (seen < lo || seen > hi) begin
         errors++;
         $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
      end
   endtask : check

   // Compares one design bit.
   task automatic check_bit(input string what, input logic exp, input logic seen);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %b seen %b", what, exp, seen);
      end
   endtask : check_bit

   // Counts cycles until the supply reaches a level, giving up at a limit.
   task automatic wait_supply(input logic lvl, input int limit, output int cyc);
      cyc = 0;
      while (target_supply !== lvl && cyc < limit) begin
         @(negedge clock);
         cyc++;
      end
   endtask : wait_supply

   // Counts cycles in which the supply was not on.
   task automatic stay_on(input string what, input int cyc);
      int bad;
      bad = 0;
      repeat (cyc) begin
         @(negedge clock);
         if (target_supply !== 1'b1) bad++;
      end
      check(what, 0, 0, bad);
   endtask : stay_on

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence of scenarios.
   initial begin
      repeat (20) @(negedge clock);
      check_bit("supply in reset", 1'b0, target_supply);
      rst_n = 1'b1;
      wait_supply(1'b1, HOLD + SLACK + 50, n);
      check("power-up delay", HOLD, HOLD + SLACK, n);
      stay_on("toggling heartbeat", 6 * WD);
      check_bit("suspended while driven", 1'b0, watchdog_suspended);
      clk_en = 1'b0;
      stay_on("frozen clock enable", 2 * WD);
      clk_en = 1'b1;
      // Stuck driven level, then floating line with pull-up fitted.
      foreach (fault[i]) begin
         mode = fault[i];
         wait_supply(1'b0, WD + 2 * SLACK, n);
         check("heartbeat timeout", WD - 130, WD + 2 * SLACK - 1, n);
         check_bit("not suspended", 1'b0, watchdog_suspended);
         mode = 2'h0;
         wait_supply(1'b1, HOLD + SLACK + 50, n);
         check("off time after timeout", HOLD, HOLD + SLACK, n);
         stay_on("restarted run", 2 * WD);
      end
      manual_power_cut_n = 1'b0;
      wait_supply(1'b0, LOOP + 80, n);
      check("cut delay", 0, LOOP + 79, n);
      repeat (2 * LOOP + int'(lfsr[4:0])) @(negedge clock);
      manual_power_cut_n = 1'b1;
      wait_supply(1'b1, HOLD + SLACK + 50, n);
      check("off time after cut", HOLD, HOLD + SLACK, n);
      stay_on("after manual restart", WD);
      mode = 2'h2;
      stay_on("undriven heartbeat", 4 * WD);
      check_bit("suspended flag", 1'b1, watchdog_suspended);
      mode = 2'h0;
      stay_on("driven again", 2 * WD);
      check_bit("suspended cleared", 1'b0, watchdog_suspended);
      tally_and_finish();
   end

   // Cuts a hang short.
   initial begin
      repeat (LIMIT) @(posedge clock);
      errors++;
      tally_and_finish();
   end
endmodule : tb_latchup_power_cycle_watchdog
